/* rtl/pctl_regs.vh */
// pctl_regs.vh: constants of the per-port basic control register and its
// serial management port; no logic, definitions only.
`ifndef PCTL_REGS_VH
`define PCTL_REGS_VH

// register address and field positions
`define PCTL_REG_CTRL      5'h00
`define PCTL_BIT_RESET     15
`define PCTL_BIT_LOOP      14
`define PCTL_BIT_SPEED     13
`define PCTL_BIT_ANEN      12
`define PCTL_BIT_PDOWN     11
`define PCTL_BIT_ISOL      10
`define PCTL_BIT_RESTART   9
`define PCTL_BIT_DUPLEX    8
`define PCTL_RSVD_W        8
`define PCTL_RSVD_ZERO     8'h00

// reset values of stored fields
`define PCTL_RST_LOOP      1'h0
`define PCTL_RST_SPEED     1'h0
`define PCTL_RST_ANEN_TP   1'h1
`define PCTL_RST_PDOWN     1'h0
`define PCTL_RST_ISOL      1'h0
`define PCTL_RST_DUPLEX    1'h0

// software reset duration and clock period
`define PCTL_SWRST_NS      1000
`define PCTL_CLK_NS        50
`define PCTL_CNT_W         5

// management frame fields
`define PCTL_PORTS         8
`define PCTL_PHYAD_HI      2'h0
`define PCTL_OP_READ       2'h2
`define PCTL_OP_WRITE      2'h1
`define PCTL_HDR_LAST      4'hb
`define PCTL_DATA_LAST     4'hf
`define PCTL_TA_LAST       4'h1

`endif

/* rtl/pctl_port.v */
// pctl_port.v: one port's copy of the basic control register.
// assumes wr_en is a one-cycle pulse on clk; straps already synchronised.
`timescale 1ns/100ps
module pctl_port (
   clk,
   rst,
   wr_en,
   wdata,
   fiber_100_mode,
   fiber_duplex_strap,
   neg_speed_100,
   neg_full_duplex,
   rdata,
   port_reset_r,
   loopback_r,
   speed_100_r,
   autoneg_en_r,
   power_down_r,
   isolate_r,
   autoneg_restart_r,
   full_duplex_r
);
`include "pctl_regs.vh"
   input wire clk;
   input wire rst;
   input wire wr_en;
   input wire [15:0] wdata;
   input wire fiber_100_mode;
   input wire fiber_duplex_strap;
   input wire neg_speed_100;
   input wire neg_full_duplex;
   output wire [15:0] rdata;
   output reg port_reset_r;
   output reg loopback_r;
   output reg speed_100_r;
   output reg autoneg_en_r;
   output reg power_down_r;
   output reg isolate_r;
   output reg autoneg_restart_r;
   output reg full_duplex_r;

   localparam integer RST_CYC_I =
      (`PCTL_SWRST_NS + `PCTL_CLK_NS - 1) / `PCTL_CLK_NS;
   localparam [`PCTL_CNT_W-1:0] RST_CYC = RST_CYC_I[`PCTL_CNT_W-1:0];
   localparam [`PCTL_CNT_W-1:0] CNT_ZERO = {`PCTL_CNT_W{1'b0}};
   localparam [`PCTL_CNT_W-1:0] CNT_ONE = {{(`PCTL_CNT_W-1){1'b0}}, 1'b1};

   reg loop_r, spd_r, an_r, pd_r, iso_r, dup_r, init_r;
   reg [`PCTL_CNT_W-1:0] rst_cnt_r;
   wire busy = (rst_cnt_r != CNT_ZERO) | init_r;
   wire an_eff = an_r & ~fiber_100_mode;
   wire def_dup = fiber_100_mode & fiber_duplex_strap;
   wire spd_eff = fiber_100_mode ? 1'b1 : (an_eff ? neg_speed_100 : spd_r);
   wire dup_eff = an_eff ? neg_full_duplex : dup_r;

   // self-clearing bits read zero, reserved bits read zero
   assign rdata = {1'b0, loop_r, spd_eff, an_eff, pd_r, iso_r, 1'b0, dup_eff,
                   `PCTL_RSVD_ZERO};

   always @(posedge clk) begin
      autoneg_restart_r <= 1'b0;
      if (rst) begin
         loop_r <= `PCTL_RST_LOOP;
         spd_r <= `PCTL_RST_SPEED;
         an_r <= `PCTL_RST_ANEN_TP;
         pd_r <= `PCTL_RST_PDOWN;
         iso_r <= `PCTL_RST_ISOL;
         dup_r <= `PCTL_RST_DUPLEX;
         rst_cnt_r <= CNT_ZERO;
         init_r <= 1'b1;
      end else if (init_r) begin
         // fiber-dependent defaults caught after reset release
         an_r <= ~fiber_100_mode;
         dup_r <= def_dup;
         init_r <= 1'b0;
      end else if (rst_cnt_r != CNT_ZERO) begin
         rst_cnt_r <= rst_cnt_r - CNT_ONE;
         if (rst_cnt_r == CNT_ONE)
            init_r <= 1'b1;
      end else if (wr_en) begin
         if (wdata[`PCTL_BIT_RESET]) begin
            loop_r <= `PCTL_RST_LOOP;
            spd_r <= `PCTL_RST_SPEED;
            an_r <= `PCTL_RST_ANEN_TP;
            pd_r <= `PCTL_RST_PDOWN;
            iso_r <= `PCTL_RST_ISOL;
            dup_r <= `PCTL_RST_DUPLEX;
            rst_cnt_r <= RST_CYC;
         end else begin
            loop_r <= wdata[`PCTL_BIT_LOOP];
            pd_r <= wdata[`PCTL_BIT_PDOWN];
            iso_r <= wdata[`PCTL_BIT_ISOL];
            if (!fiber_100_mode)
               an_r <= wdata[`PCTL_BIT_ANEN];
            if (!an_eff && !fiber_100_mode)
               spd_r <= wdata[`PCTL_BIT_SPEED];
            if (!an_eff)
               dup_r <= wdata[`PCTL_BIT_DUPLEX];
            autoneg_restart_r <= wdata[`PCTL_BIT_RESTART] & an_eff;
         end
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         port_reset_r <= 1'b1;
         loopback_r <= 1'b0;
         speed_100_r <= 1'b0;
         autoneg_en_r <= 1'b0;
         power_down_r <= 1'b0;
         isolate_r <= 1'b0;
         full_duplex_r <= 1'b0;
      end else begin
         port_reset_r <= busy;
         loopback_r <= loop_r;
         speed_100_r <= spd_eff;
         autoneg_en_r <= an_eff;
         power_down_r <= pd_r;
         isolate_r <= iso_r;
         full_duplex_r <= dup_eff;
      end
   end
endmodule

/* rtl/pctl_mgmt.v */
// pctl_mgmt.v: serial management slave and eight per-port control registers.
// assumes mdc/mdio and strap pins are asynchronous to clk; mdc well below clk/6.
// assumes negotiated speed and duplex come from logic on clk.
`timescale 1ns/100ps
module pctl_mgmt (
   clk,
   rst,
   mdc,
   mdio_i,
   mdio_o,
   mdio_oe,
   fiber_100_mode,
   fiber_duplex_strap,
   neg_speed_100,
   neg_full_duplex,
   port_reset,
   loopback_en,
   speed_100,
   autoneg_en,
   power_down,
   isolate,
   autoneg_restart,
   full_duplex
);
`include "pctl_regs.vh"
   input wire clk;
   input wire rst;
   input wire mdc;
   input wire mdio_i;
   output reg mdio_o;
   output reg mdio_oe;
   input wire [`PCTL_PORTS-1:0] fiber_100_mode;
   input wire [`PCTL_PORTS-1:0] fiber_duplex_strap;
   input wire [`PCTL_PORTS-1:0] neg_speed_100;
   input wire [`PCTL_PORTS-1:0] neg_full_duplex;
   output wire [`PCTL_PORTS-1:0] port_reset;
   output wire [`PCTL_PORTS-1:0] loopback_en;
   output wire [`PCTL_PORTS-1:0] speed_100;
   output wire [`PCTL_PORTS-1:0] autoneg_en;
   output wire [`PCTL_PORTS-1:0] power_down;
   output wire [`PCTL_PORTS-1:0] isolate;
   output wire [`PCTL_PORTS-1:0] autoneg_restart;
   output wire [`PCTL_PORTS-1:0] full_duplex;

   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_START = 3'h1;
   localparam [2:0] S_HDR = 3'h2;
   localparam [2:0] S_TA = 3'h3;
   localparam [2:0] S_DATA = 3'h4;
   localparam [3:0] CNT_ONE = 4'h1;
   localparam [3:0] CNT_ZERO = 4'h0;

   // pin synchronisers
   reg mdc_s1_r;
   reg mdc_s2_r;
   reg mdc_d_r;
   reg mdio_s1_r;
   reg mdio_s2_r;
   reg [`PCTL_PORTS-1:0] fib_s1_r;
   reg [`PCTL_PORTS-1:0] fib_s2_r;
   reg [`PCTL_PORTS-1:0] dst_s1_r;
   reg [`PCTL_PORTS-1:0] dst_s2_r;
   always @(posedge clk) begin
      if (rst) begin
         mdc_s1_r <= 1'b0;
         mdc_s2_r <= 1'b0;
         mdc_d_r <= 1'b0;
         mdio_s1_r <= 1'b1;
         mdio_s2_r <= 1'b1;
      end else begin
         mdc_s1_r <= mdc;
         mdc_s2_r <= mdc_s1_r;
         mdc_d_r <= mdc_s2_r;
         mdio_s1_r <= mdio_i;
         mdio_s2_r <= mdio_s1_r;
      end
   end

   // straps keep syncing through reset, so the init cycle sees settled pins
   always @(posedge clk) begin
      fib_s1_r <= fiber_100_mode;
      fib_s2_r <= fib_s1_r;
      dst_s1_r <= fiber_duplex_strap;
      dst_s2_r <= dst_s1_r;
   end
   wire mdc_rise = mdc_s2_r & ~mdc_d_r;
   wire bit_in = mdio_s2_r;

   // frame decoder
   reg [2:0] state_r;
   reg [3:0] cnt_r;
   reg [11:0] hdr_r;
   reg [15:0] shift_r;
   reg ones_r;
   reg rd_r;
   reg hit_r;
   reg [2:0] port_r;
   reg [`PCTL_PORTS-1:0] wr_r;
   wire [16*`PCTL_PORTS-1:0] rdata_all;
   wire [11:0] hdr_nxt = {hdr_r[10:0], bit_in};
   wire [2:0] port_nxt = hdr_nxt[7:5];
   wire hit_nxt = (hdr_nxt[9:8] == `PCTL_PHYAD_HI) && (hdr_nxt[4:0] == `PCTL_REG_CTRL);

   always @(posedge clk) begin
      wr_r <= {`PCTL_PORTS{1'b0}};
      if (rst) begin
         state_r <= S_IDLE;
         cnt_r <= CNT_ZERO;
         hdr_r <= 12'h000;
         shift_r <= 16'h0000;
         ones_r <= 1'b0;
         rd_r <= 1'b0;
         hit_r <= 1'b0;
         port_r <= 3'h0;
         mdio_o <= 1'b0;
         mdio_oe <= 1'b0;
      end else if (mdc_rise) begin
         case (state_r)
            // an idle one followed by the first start bit opens a frame
            S_IDLE: begin
               ones_r <= bit_in;
               if (!bit_in && ones_r)
                  state_r <= S_START;
            end
            S_START: begin
               cnt_r <= CNT_ZERO;
               ones_r <= 1'b0;
               state_r <= bit_in ? S_HDR : S_IDLE;
            end
            // op, phy address and register address, msb first
            S_HDR: begin
               hdr_r <= hdr_nxt;
               cnt_r <= cnt_r + CNT_ONE;
               if (cnt_r == `PCTL_HDR_LAST) begin
                  rd_r <= (hdr_nxt[11:10] == `PCTL_OP_READ);
                  hit_r <= hit_nxt &&
                     ((hdr_nxt[11:10] == `PCTL_OP_READ) ||
                      (hdr_nxt[11:10] == `PCTL_OP_WRITE));
                  port_r <= port_nxt;
                  shift_r <= rdata_all[16*port_nxt +: 16];
                  cnt_r <= CNT_ZERO;
                  state_r <= S_TA;
               end
            end
            // first turnaround bit: take the line for a hit read
            S_TA: begin
               cnt_r <= cnt_r + CNT_ONE;
               if (cnt_r != `PCTL_TA_LAST) begin
                  mdio_oe <= rd_r & hit_r;
                  mdio_o <= 1'b0;
               end else begin
                  cnt_r <= CNT_ZERO;
                  state_r <= S_DATA;
                  if (rd_r) begin
                     mdio_o <= shift_r[15];
                     shift_r <= {shift_r[14:0], 1'b0};
                  end
               end
            end
            S_DATA: begin
               cnt_r <= cnt_r + CNT_ONE;
               if (rd_r) begin
                  mdio_o <= shift_r[15];
                  shift_r <= {shift_r[14:0], 1'b0};
               end else begin
                  shift_r <= {shift_r[14:0], bit_in};
               end
               // last data bit: release the line, deliver a hit write
               if (cnt_r == `PCTL_DATA_LAST) begin
                  mdio_oe <= 1'b0;
                  mdio_o <= 1'b0;
                  state_r <= S_IDLE;
                  ones_r <= 1'b0;
                  if (!rd_r && hit_r)
                     wr_r[port_r] <= 1'b1;
               end
            end
            default: begin
               state_r <= S_IDLE;
               mdio_oe <= 1'b0;
            end
         endcase
      end
   end

   // one register copy per port
   genvar g;
   generate
      for (g = 0; g < `PCTL_PORTS; g = g + 1) begin : g_port
         pctl_port u_port (
            .clk(clk),
            .rst(rst),
            .wr_en(wr_r[g]),
            .wdata(shift_r),
            .fiber_100_mode(fib_s2_r[g]),
            .fiber_duplex_strap(dst_s2_r[g]),
            .neg_speed_100(neg_speed_100[g]),
            .neg_full_duplex(neg_full_duplex[g]),
            .rdata(rdata_all[16*g +: 16]),
            .port_reset_r(port_reset[g]),
            .loopback_r(loopback_en[g]),
            .speed_100_r(speed_100[g]),
            .autoneg_en_r(autoneg_en[g]),
            .power_down_r(power_down[g]),
            .isolate_r(isolate[g]),
            .autoneg_restart_r(autoneg_restart[g]),
            .full_duplex_r(full_duplex[g])
         );
      end
   endgenerate
endmodule

/* verification/pctl_mgmt_assertions.sv */
// pctl_mgmt_assertions.sv: port checks on the management register block.
// assumes straps and negotiated inputs stay steady while out of reset.
`timescale 1ns/100ps
module pctl_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic mdio_oe,
   input wire logic [7:0] fiber_100_mode,
   input wire logic [7:0] neg_speed_100,
   input wire logic [7:0] neg_full_duplex,
   input wire logic [7:0] port_reset,
   input wire logic [7:0] loopback_en,
   input wire logic [7:0] speed_100,
   input wire logic [7:0] autoneg_en,
   input wire logic [7:0] power_down,
   input wire logic [7:0] isolate,
   input wire logic [7:0] autoneg_restart,
   input wire logic [7:0] full_duplex
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_fiber_speed_one: assert property (
      (fiber_100_mode & ~port_reset & ~speed_100) == 8'h00) else $error("fiber speed low");
   a_fiber_an_off: assert property (
      (fiber_100_mode & autoneg_en) == 8'h00) else $error("fiber negotiation on");
   a_an_speed_shown: assert property (
      (autoneg_en & ~port_reset & (speed_100 ^ neg_speed_100)) == 8'h00)
      else $error("speed not negotiated");
   a_an_duplex_shown: assert property (
      (autoneg_en & ~port_reset & (full_duplex ^ neg_full_duplex)) == 8'h00)
      else $error("duplex not negotiated");
   a_restart_single: assert property (
      autoneg_restart[0] |=> !autoneg_restart[0]) else $error("restart too long");
   a_restart_needs_an: assert property (
      (autoneg_restart & ~(autoneg_en | $past(autoneg_en))) == 8'h00)
      else $error("restart without negotiation");
   a_hw_defaults: assert property (
      $fell(rst) |-> port_reset == 8'hff && loopback_en == 8'h00 && isolate == 8'h00
      && power_down == 8'h00 && !mdio_oe) else $error("reset state wrong");
   a_swrst_length: assert property (
      $rose(port_reset[0]) |-> port_reset[0] [*8] ##12 port_reset[0] ##[1:6] !port_reset[0])
      else $error("port reset length wrong");
   a_swrst_fields: assert property (
      port_reset[0] && $past(port_reset[0]) |-> !loopback_en[0] && !power_down[0]
      && !isolate[0]) else $error("fields kept in reset");
endmodule
bind pctl_mgmt pctl_chk u_chk (.clk, .rst, .mdio_oe, .fiber_100_mode, .neg_speed_100,
   .neg_full_duplex, .port_reset, .loopback_en, .speed_100, .autoneg_en, .power_down,
   .isolate, .autoneg_restart, .full_duplex);

/* verification/pctl_mac_model.sv */
// pctl_mac_model.sv: station manager clocking management frames.
// assumes mdio_w already resolves both drivers and the pull-up.
`timescale 1ns/100ps
`include "pctl_regs.vh"
module pctl_mac_model (
   input wire logic clk,
   input wire logic mdio_w,
   output logic mdc,
   output logic mac_o,
   output logic mac_oe
);
   initial begin
      mdc = 1'b0;
      mac_o = 1'b1;
      mac_oe = 1'b0;
   end
   // data set in low half, line sampled just before the rising edge
   task automatic bit_x(input logic d, input logic drv, output logic s);
      @(posedge clk);
      mdc <= 1'b0;
      mac_o <= d;
      mac_oe <= drv;
      repeat (4) @(posedge clk);
      s = mdio_w;
      mdc <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   // reserved data bits go out as given, so refusals can be exercised
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rd);
      logic [17:0] hdr;
      logic s;
      logic wr;
      hdr = {2'b11, 2'b01, op, phy, ra, 2'b10};
      wr = (op == `PCTL_OP_WRITE);
      for (int i = 17; i >= 0; i--) bit_x(hdr[i], wr || i > 1, s);
      for (int i = 15; i >= 0; i--) bit_x(wd[i], wr, rd[i]);
      @(posedge clk);
      mdc <= 1'b0;
      mac_oe <= 1'b0;
   endtask
endmodule

/* verification/phy_port_control_register_test.sv */
// phy_port_control_register_test.sv: frame-level tests of the port registers.
// assumes the include path reaches rtl/ for pctl_regs.vh.
`timescale 1ns/100ps
`include "pctl_regs.vh"
module phy_port_control_register_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic mdc, mac_o, mac_oe, mdio_o, mdio_oe;
   logic [7:0] fiber_100_mode = 8'h80;
   logic [7:0] fiber_duplex_strap = 8'h80;
   logic [7:0] neg_speed_100 = 8'h01;
   logic [7:0] neg_full_duplex = 8'h01;
   wire [7:0] port_reset, loopback_en, speed_100, autoneg_en;
   wire [7:0] power_down, isolate, autoneg_restart, full_duplex;
   wire mdio_w = mdio_oe ? mdio_o : (mac_oe ? mac_o : 1'b1);
   int failures = 0;
   int checked = 0;
   int rs_cnt = 0;
   int pr_cnt = 0;
   int pr_base = 0;
   logic [15:0] rd;
   always #25 clk = ~clk;
   always @(posedge clk) begin
      if (!rst && autoneg_restart[0]) rs_cnt++;
      if (!rst && port_reset[0]) pr_cnt++;
   end
   pctl_mgmt uut (.clk, .rst, .mdc, .mdio_i(mdio_w), .mdio_o, .mdio_oe, .fiber_100_mode,
      .fiber_duplex_strap, .neg_speed_100, .neg_full_duplex, .port_reset,
      .loopback_en(loopback_en), .speed_100, .autoneg_en, .power_down, .isolate,
      .autoneg_restart, .full_duplex);
   pctl_mac_model mac (.clk, .mdio_w, .mdc, .mac_o, .mac_oe);
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] phy, input logic [15:0] d);
      mac.frame(`PCTL_OP_WRITE, phy, 5'h00, d, rd);
   endtask
   task automatic rchk(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] exp);
      mac.frame(`PCTL_OP_READ, phy, ra, 16'h0000, rd);
      cmp16(rd, exp);
   endtask
   task automatic final_report;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      $display("unexpected at %0t: run too long", $time);
      final_report;
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      rchk(5'h00, 5'h00, 16'h3100);
      rchk(5'h01, 5'h00, 16'h1000);
      rchk(5'h07, 5'h00, 16'h2100);
      wr(5'h07, 16'h1000);
      rchk(5'h07, 5'h00, 16'h2000);
      wr(5'h00, 16'h10ff);
      rchk(5'h00, 5'h00, 16'h3100);
      wr(5'h00, 16'h4c00);
      wr(5'h00, 16'h6d00);
      rchk(5'h00, 5'h00, 16'h6d00);
      cmp16({10'h000, loopback_en[0], speed_100[0], autoneg_en[0], power_down[0],
         isolate[0], full_duplex[0]}, 16'h0037);
      rchk(5'h01, 5'h00, 16'h1000);
      wr(5'h00, 16'h0200);
      rchk(5'h00, 5'h00, 16'h0000);
      wr(5'h00, 16'h1000);
      wr(5'h00, 16'h1200);
      rchk(5'h00, 5'h00, 16'h3100);
      cmp16(rs_cnt[15:0], 16'h0001);
      rchk(5'h00, 5'h01, 16'hffff);
      rchk(5'h08, 5'h00, 16'hffff);
      wr(5'h00, 16'h4000);
      pr_base = pr_cnt;
      wr(5'h00, 16'hc000);
      rchk(5'h00, 5'h00, 16'h3100);
      cmp16({15'h0000, (pr_cnt - pr_base) >= 20 && (pr_cnt - pr_base) <= 23},
         16'h0001);
      wr(5'h00, 16'h4000);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      rchk(5'h00, 5'h00, 16'h3100);
      final_report;
   end
endmodule
